// *** src/nst_timekeeper.sv ***
// Timekeeping RAM top: 32k x 8 storage with BCD clock registers
// in the eight top locations, double-buffered against counters.
// Assumes host strobes are synchronous to core_clk and the
// outside wire is resolved from byteLinesOut/byteLinesOe.
`default_nettype none
`include "nst_map.svh"

module nst_timekeeper
   import nst_pkg::*;
#(
   parameter int SEC_CYCLES = `NST_SEC_CYCLES,
   parameter int TOG_CYCLES = `NST_TOG_CYCLES
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // host memory port
   input  wire nst_pkg::nst_bus_s hostBus,
   input  wire nst_pkg::nst_byte_t byteLinesIn,
   output nst_pkg::nst_byte_t     byteLinesOut,
   output logic                  byteLinesOe,
   // supply and battery monitors
   input  wire logic             powerFail,
   input  wire logic             batteryGood,
   // status
   output logic                  oscillatorStopped,
   output logic                  updatesFrozen
);
   import nst_pkg::*;

   // ---------------------------------------------------------
   // storage and visible registers
   // ---------------------------------------------------------
   nst_byte_t memArray [0:`NST_MEM_WORDS-1];
   nst_byte_t viewReg  [0:7];
   nst_byte_t fieldMask [0:7];

   logic       accessOk;
   logic       clkSel;
   logic [2:0] regIdx;
   logic       readCycle;
   logic       writeCycle;
   logic       writeClk;
   logic       writeMem;

   logic       readHold;
   logic       writeHold;
   logic       writeHoldPrev_reg;
   logic       loadPulse;
   logic       freeze;
   logic       oscStop;
   logic       freqTest;

   logic       secTick;
   logic       testToggle;

   logic [7:0] cntVal   [0:7];
   logic [7:0] cntMin   [0:7];
   logic [7:0] cntMax   [0:7];
   logic       cntInc   [0:7];
   logic       cntCarry [0:7];
   logic [7:0] daysInMonth;
   logic       leapYear;

   // ---------------------------------------------------------
   // host cycle decode
   // ---------------------------------------------------------
   // write wins over read when both strobes are low
   // no access at all while the supply monitor flags a fault
   assign accessOk   = !powerFail && !hostBus.ceN;
   assign readCycle  = accessOk && !hostBus.oeN && hostBus.weN;
   assign writeCycle = accessOk && !hostBus.weN;
   assign clkSel     = (hostBus.locationLines[14:3]
                        == `NST_CLK_BLOCK);
   assign regIdx     = hostBus.locationLines[2:0];
   assign writeClk   = writeCycle && clkSel;
   assign writeMem   = writeCycle && !clkSel;

   // ---------------------------------------------------------
   // control bits held in the visible registers
   // ---------------------------------------------------------
   assign writeHold = viewReg[`NST_IDX_CENT][`NST_BIT_WHOLD];
   assign readHold  = viewReg[`NST_IDX_CENT][`NST_BIT_RHOLD];
   assign oscStop   = viewReg[`NST_IDX_SEC][`NST_BIT_OSCSTOP];
   assign freqTest  = viewReg[`NST_IDX_DAY][`NST_BIT_FTEST];
   // load a cycle after write-hold falls, with refresh held off
   assign loadPulse = writeHoldPrev_reg && !writeHold;
   assign freeze    = readHold || writeHold || loadPulse;

   assign fieldMask[`NST_IDX_CENT]  = `NST_MASK_CENT;
   assign fieldMask[`NST_IDX_SEC]   = `NST_MASK_SEC;
   assign fieldMask[`NST_IDX_MIN]   = `NST_MASK_MIN;
   assign fieldMask[`NST_IDX_HOUR]  = `NST_MASK_HOUR;
   assign fieldMask[`NST_IDX_DAY]   = `NST_MASK_DAY;
   assign fieldMask[`NST_IDX_DATE]  = `NST_MASK_DATE;
   assign fieldMask[`NST_IDX_MONTH] = `NST_MASK_MONTH;
   assign fieldMask[`NST_IDX_YEAR]  = `NST_MASK_YEAR;

   // ---------------------------------------------------------
   // oscillator
   // ---------------------------------------------------------
   // stop bit halts both the tick and the test toggle
   nst_tick_gen #(
      .SEC_CYCLES (SEC_CYCLES),
      .TOG_CYCLES (TOG_CYCLES)
   ) u_tick (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .run        (!oscStop),
      .secTick    (secTick),
      .testToggle (testToggle)
   );

   // ---------------------------------------------------------
   // calendar limits
   // ---------------------------------------------------------
   // year divisible by four; the 2100 exception is not kept
   always_comb begin
      if (cntVal[`NST_IDX_YEAR][4]) begin
         leapYear = (cntVal[`NST_IDX_YEAR][3:0] == 4'h2)
                 || (cntVal[`NST_IDX_YEAR][3:0] == 4'h6);
      end else begin
         leapYear = (cntVal[`NST_IDX_YEAR][3:0] == 4'h0)
                 || (cntVal[`NST_IDX_YEAR][3:0] == 4'h4)
                 || (cntVal[`NST_IDX_YEAR][3:0] == 4'h8);
      end
   end

   always_comb begin
      if (cntVal[`NST_IDX_MONTH] == `NST_MONTH_FEB) begin
         daysInMonth = leapYear ? `NST_DIM_29 : `NST_DIM_28;
      end else if (cntVal[`NST_IDX_MONTH] == `NST_MONTH_APR
                || cntVal[`NST_IDX_MONTH] == `NST_MONTH_JUN
                || cntVal[`NST_IDX_MONTH] == `NST_MONTH_SEP
                || cntVal[`NST_IDX_MONTH] == `NST_MONTH_NOV) begin
         daysInMonth = `NST_DIM_30;
      end else begin
         daysInMonth = `NST_DIM_31;
      end
   end

   assign cntMin[`NST_IDX_CENT]  = `NST_ZERO;
   assign cntMin[`NST_IDX_SEC]   = `NST_ZERO;
   assign cntMin[`NST_IDX_MIN]   = `NST_ZERO;
   assign cntMin[`NST_IDX_HOUR]  = `NST_ZERO;
   assign cntMin[`NST_IDX_DAY]   = `NST_ONE;
   assign cntMin[`NST_IDX_DATE]  = `NST_ONE;
   assign cntMin[`NST_IDX_MONTH] = `NST_ONE;
   assign cntMin[`NST_IDX_YEAR]  = `NST_ZERO;

   // minutes share the seconds limit of 59
   assign cntMax[`NST_IDX_CENT]  = `NST_MAX_CENT;
   assign cntMax[`NST_IDX_SEC]   = `NST_MAX_SEC;
   assign cntMax[`NST_IDX_MIN]   = `NST_MAX_SEC;
   assign cntMax[`NST_IDX_HOUR]  = `NST_MAX_HOUR;
   assign cntMax[`NST_IDX_DAY]   = `NST_MAX_DAY;
   assign cntMax[`NST_IDX_DATE]  = daysInMonth;
   assign cntMax[`NST_IDX_MONTH] = `NST_MAX_MONTH;
   assign cntMax[`NST_IDX_YEAR]  = `NST_MAX_YEAR;

   // ripple of carries; counters idle while oscillator stopped
   assign cntInc[`NST_IDX_SEC]   = secTick;
   assign cntInc[`NST_IDX_MIN]   = cntCarry[`NST_IDX_SEC];
   assign cntInc[`NST_IDX_HOUR]  = cntCarry[`NST_IDX_MIN];
   assign cntInc[`NST_IDX_DAY]   = cntCarry[`NST_IDX_HOUR];
   assign cntInc[`NST_IDX_DATE]  = cntCarry[`NST_IDX_HOUR];
   assign cntInc[`NST_IDX_MONTH] = cntCarry[`NST_IDX_DATE];
   assign cntInc[`NST_IDX_YEAR]  = cntCarry[`NST_IDX_MONTH];
   assign cntInc[`NST_IDX_CENT]  = cntCarry[`NST_IDX_YEAR];

   // ---------------------------------------------------------
   // internal counters, apart from the visible copy
   // ---------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_cnt
      localparam logic [7:0] RST_V =
         (i == 0) ? `NST_RST_CENT :
         (i == 4 || i == 5 || i == 6) ? `NST_RST_CAL :
         (i == 7) ? `NST_RST_YEAR : `NST_RST_TIME;
      nst_bcd_counter #(
         .RST_VAL (RST_V)
      ) u_cnt (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .inc      (cntInc[i]),
         .load     (loadPulse),
         .loadVal  (viewReg[i] & fieldMask[i]),
         .minVal   (cntMin[i]),
         .maxVal   (cntMax[i]),
         .value    (cntVal[i]),
         .carry    (cntCarry[i])
      );
   end

   // ---------------------------------------------------------
   // write-hold edge
   // ---------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         writeHoldPrev_reg <= 1'b0;
      end else begin
         writeHoldPrev_reg <= writeHold;
      end
   end

   // ---------------------------------------------------------
   // visible registers: host writes win, else refresh
   // ---------------------------------------------------------
   // limitation: a time field written with no hold bit set
   // is overwritten by the refresh on the very next cycle
   for (genvar j = 0; j < 8; j++) begin : g_view
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            viewReg[j] <= `NST_ZERO;
         end else if (writeClk && regIdx == 3'(j)) begin
            viewReg[j] <= byteLinesIn;
         end else if (!freeze) begin
            // every field in one step; spare bits stay as RAM
            viewReg[j] <= (viewReg[j] & ~fieldMask[j])
                        | (cntVal[j] & fieldMask[j]);
         end
      end
   end

   // ---------------------------------------------------------
   // ordinary storage, not reset: it is the nonvolatile part
   // ---------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (writeMem) begin
         memArray[hostBus.locationLines] <= byteLinesIn;
      end
   end

   // ---------------------------------------------------------
   // read path, re-sampled every cycle so line 0 tracks toggle
   // ---------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         byteLinesOe <= 1'b0;
      end else begin
         byteLinesOe <= readCycle;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         byteLinesOut <= `NST_ZERO;
      end else if (!readCycle) begin
         byteLinesOut <= `NST_ZERO;
      end else if (!clkSel) begin
         byteLinesOut <= memArray[hostBus.locationLines];
      end else if (regIdx == `NST_IDX_DAY) begin
         byteLinesOut <= {batteryGood,
                          viewReg[`NST_IDX_DAY][6:0]};
      end else if (regIdx == `NST_IDX_SEC && freqTest
                   && !oscStop) begin
         byteLinesOut <= {viewReg[`NST_IDX_SEC][7:1],
                          testToggle};
      end else begin
         byteLinesOut <= viewReg[regIdx];
      end
   end

   // ---------------------------------------------------------
   // status
   // ---------------------------------------------------------
   // status copies lag the control bits by one cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         oscillatorStopped <= 1'b0;
         updatesFrozen     <= 1'b0;
      end else begin
         oscillatorStopped <= oscStop;
         updatesFrozen     <= readHold || writeHold;
      end
   end
endmodule : nst_timekeeper

`default_nettype wire

// *** src/nst_map.svh ***
// Constants of the timekeeping RAM: locations, field layouts,
// reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef NST_MAP_SVH
`define NST_MAP_SVH

// ------------------------------------------------------------
// memory geometry
// ------------------------------------------------------------
`define NST_ADDR_W        15
`define NST_DATA_W        8
`define NST_MEM_WORDS     32768
`define NST_CLK_BLOCK     12'hFFF

// ------------------------------------------------------------
// clock register indices, from the lowest of the top eight
// ------------------------------------------------------------
`define NST_IDX_CENT      3'h0
`define NST_IDX_SEC       3'h1
`define NST_IDX_MIN       3'h2
`define NST_IDX_HOUR      3'h3
`define NST_IDX_DAY       3'h4
`define NST_IDX_DATE      3'h5
`define NST_IDX_MONTH     3'h6
`define NST_IDX_YEAR      3'h7

// ------------------------------------------------------------
// control bit positions
// ------------------------------------------------------------
`define NST_BIT_WHOLD     7
`define NST_BIT_RHOLD     6
`define NST_BIT_OSCSTOP   7
`define NST_BIT_FTEST     6
`define NST_BIT_BATTGOOD  7

// ------------------------------------------------------------
// time field masks within each register
// ------------------------------------------------------------
`define NST_MASK_CENT     8'h3F
`define NST_MASK_SEC      8'h7F
`define NST_MASK_MIN      8'h7F
`define NST_MASK_HOUR     8'h3F
`define NST_MASK_DAY      8'h07
`define NST_MASK_DATE     8'h3F
`define NST_MASK_MONTH    8'h1F
`define NST_MASK_YEAR     8'hFF

// ------------------------------------------------------------
// BCD ranges
// ------------------------------------------------------------
`define NST_MAX_CENT      8'h39
`define NST_MAX_SEC       8'h59
`define NST_MAX_HOUR      8'h23
`define NST_MAX_DAY       8'h07
`define NST_MAX_MONTH     8'h12
`define NST_MAX_YEAR      8'h99
`define NST_DIM_31        8'h31
`define NST_DIM_30        8'h30
`define NST_DIM_29        8'h29
`define NST_DIM_28        8'h28
`define NST_MONTH_FEB     8'h02
`define NST_MONTH_APR     8'h04
`define NST_MONTH_JUN     8'h06
`define NST_MONTH_SEP     8'h09
`define NST_MONTH_NOV     8'h11
`define NST_ZERO          8'h00
`define NST_ONE           8'h01

// ------------------------------------------------------------
// reset values of the counters
// ------------------------------------------------------------
`define NST_RST_CENT      8'h20
`define NST_RST_YEAR      8'h00
`define NST_RST_CAL       8'h01
`define NST_RST_TIME      8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define NST_CLK_HZ        20000000
`define NST_TICK_HZ       1
`define NST_FTEST_HZ      512
`define NST_SEC_CYCLES    (`NST_CLK_HZ / `NST_TICK_HZ)
`define NST_TOG_CYCLES    (`NST_CLK_HZ / (2 * `NST_FTEST_HZ))

`endif

// *** src/nst_pkg.sv ***
// Types shared by the timekeeping RAM design.
// Assumes nst_map.svh is on the include path.
`default_nettype none
`include "nst_map.svh"

package nst_pkg;

   // ---------------------------------------------------------
   // host strobes and location, all active-low strobes
   // ---------------------------------------------------------
   typedef struct packed {
      logic                      ceN;
      logic                      oeN;
      logic                      weN;
      logic [`NST_ADDR_W-1:0]    locationLines;
   } nst_bus_s;

   typedef logic [`NST_DATA_W-1:0] nst_byte_t;

endpackage : nst_pkg

`default_nettype wire

// *** src/nst_bcd_counter.sv ***
// One packed-BCD field counter with load, wrap and carry.
// Assumes min/max are valid BCD and the loaded value is in range.
`default_nettype none
`include "nst_map.svh"

module nst_bcd_counter #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // control
   input  wire logic        inc,
   input  wire logic        load,
   input  wire logic [7:0]  loadVal,
   input  wire logic [7:0]  minVal,
   input  wire logic [7:0]  maxVal,
   // result
   output logic [7:0]       value,
   output logic             carry
);
   logic [7:0] countNext;

   always_comb begin
      if (value >= maxVal) begin
         countNext = minVal;
      end else if (value[3:0] == 4'h9) begin
         countNext = {value[7:4] + 4'h1, 4'h0};
      end else begin
         countNext = {value[7:4], value[3:0] + 4'h1};
      end
   end

   assign carry = inc && (value >= maxVal);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         value <= RST_VAL;
      end else if (load) begin
         value <= loadVal;
      end else if (inc) begin
         value <= countNext;
      end
   end
endmodule : nst_bcd_counter

`default_nettype wire

// *** src/nst_tick_gen.sv ***
// Oscillator model: one-second tick and test-frequency toggle.
// Assumes core_clk is the only timebase; run low freezes both.
`default_nettype none
`include "nst_map.svh"

module nst_tick_gen #(
   parameter int SEC_CYCLES = `NST_SEC_CYCLES,
   parameter int TOG_CYCLES = `NST_TOG_CYCLES
) (
   // clock and reset
   input  wire logic  core_clk,
   input  wire logic  rst_n,
   // control
   input  wire logic  run,
   // outputs
   output logic       secTick,
   output logic       testToggle
);
   logic [31:0] secCount_reg;
   logic [31:0] togCount_reg;
   logic        secWrap;
   logic        togWrap;

   assign secWrap = (secCount_reg == 32'(SEC_CYCLES - 1));
   assign togWrap = (togCount_reg == 32'(TOG_CYCLES - 1));

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         secCount_reg <= 32'h0;
         secTick      <= 1'b0;
      end else if (run) begin
         secCount_reg <= secWrap ? 32'h0 : secCount_reg + 32'h1;
         secTick      <= secWrap;
      end else begin
         secTick      <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         togCount_reg <= 32'h0;
         testToggle   <= 1'b0;
      end else if (run) begin
         togCount_reg <= togWrap ? 32'h0 : togCount_reg + 32'h1;
         if (togWrap) begin
            testToggle <= !testToggle;
         end
      end
   end
endmodule : nst_tick_gen

`default_nettype wire

// *** sim/nst_props.sv ***
// Checker for the timekeeping RAM top, bound to its ports.
// Assumes host strobes are sampled on core_clk rising edges.
`default_nettype none

module nst_props
   import nst_pkg::*;
#(
   parameter int SEC_CYCLES = 40,
   parameter int TOG_CYCLES = 5
) (
   // clock and reset
   input wire logic               core_clk,
   input wire logic               rst_n,
   // host memory port
   input wire nst_pkg::nst_bus_s  hostBus,
   input wire nst_pkg::nst_byte_t byteLinesIn,
   input wire nst_pkg::nst_byte_t byteLinesOut,
   input wire logic               byteLinesOe,
   // monitors and status
   input wire logic               powerFail,
   input wire logic               batteryGood,
   input wire logic               oscillatorStopped,
   input wire logic               updatesFrozen
);
   // --------
   // decoded host cycles
   // --------
   logic        rdc;
   logic        wrc;
   logic [14:0] loc;

   assign loc = hostBus.locationLines;
   assign rdc = !hostBus.ceN && !hostBus.oeN && hostBus.weN && !powerFail;
   assign wrc = !hostBus.ceN && !hostBus.weN && !powerFail;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   rd_drive_a: assert property (rdc |=> byteLinesOe)
      else $error("read cycle left lines undriven");
   idle_quiet_a: assert property (!rdc |=>
      !byteLinesOe && byteLinesOut == 8'h00)
      else $error("lines driven outside a read");
   pf_block_a: assert property (powerFail |=> !byteLinesOe)
      else $error("driven during supply fault");
   ram_echo_a: assert property ((wrc && loc < 15'h7FF8) ##1
      (rdc && loc == $past(loc)) |=> byteLinesOut == $past(byteLinesIn, 2))
      else $error("stored byte not read back");
   bat_flag_a: assert property (rdc && loc == 15'h7FFC |=>
      byteLinesOut[7] == $past(batteryGood))
      else $error("battery flag wrong on day read");
   osc_copy_a: assert property (wrc && loc == 15'h7FF9 |-> ##2
      oscillatorStopped == $past(byteLinesIn[7], 2))
      else $error("oscillator stop state wrong");
   hold_flag_a: assert property (wrc && loc == 15'h7FF8 |-> ##2
      updatesFrozen == ($past(byteLinesIn[7], 2) || $past(byteLinesIn[6], 2)))
      else $error("hold state wrong after century write");
   // seconds and day excluded: test toggle and battery flag move them
   hold_stable_a: assert property (rdc && $past(rdc) && $stable(loc)
      && updatesFrozen && loc[14:3] == 12'hFFF && loc[2:0] != 3'h1
      && loc[2:0] != 3'h4 |=> $stable(byteLinesOut))
      else $error("frozen register changed");
   reset_quiet_a: assert property (@(posedge core_clk) disable iff (1'b0)
      !rst_n |=> !byteLinesOe && !updatesFrozen && !oscillatorStopped)
      else $error("outputs active in reset");

   cover property (rdc && loc == 15'h7FF9);
   cover property (wrc && loc == 15'h7FF8 && byteLinesIn[7]);
   cover property (powerFail && !hostBus.ceN);

endmodule : nst_props

bind nst_timekeeper nst_props #(
   .SEC_CYCLES(SEC_CYCLES), .TOG_CYCLES(TOG_CYCLES)
) u_props (
   .core_clk(core_clk), .rst_n(rst_n), .hostBus(hostBus),
   .byteLinesIn(byteLinesIn), .byteLinesOut(byteLinesOut),
   .byteLinesOe(byteLinesOe), .powerFail(powerFail),
   .batteryGood(batteryGood), .oscillatorStopped(oscillatorStopped),
   .updatesFrozen(updatesFrozen)
);

`default_nettype wire

// *** sim/nst_host_model.sv ***
// Host processor model driving the asynchronous memory strobes.
// Assumes every strobe change lands just after a core_clk edge.
`default_nettype none

module nst_host_model
   import nst_pkg::*;
(
   // clock
   input  wire logic               core_clk,
   // memory port
   output var  nst_pkg::nst_bus_s  bus,
   output var  nst_pkg::nst_byte_t wrData,
   input  wire nst_pkg::nst_byte_t rdData,
   input  wire logic               rdOe
);
   // --------
   // bus cycles
   // --------
   localparam nst_bus_s IDLE = '{1'b1, 1'b1, 1'b1, 15'h0000};

   initial begin
      bus = IDLE;
      wrData = 8'h00;
   end

   // write stays asserted until the caller's next cycle starts
   task automatic wr(input logic [14:0] a, input nst_byte_t d);
      @(posedge core_clk);
      bus <= '{1'b0, 1'b1, 1'b0, a};
      wrData <= d;
   endtask : wr

   // released data lines flip every cycle, never the same byte twice running
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge core_clk);
         bus <= IDLE;
         wrData <= ~wrData;
      end
   endtask : idle

   task automatic rd(input logic [14:0] a, output nst_byte_t d,
                     output logic oe);
      @(posedge core_clk);
      bus <= '{1'b0, 1'b0, 1'b1, a};
      wrData <= ~wrData;
      repeat (2) @(posedge core_clk);
      d = rdData;
      oe = rdOe;
      bus <= IDLE;
   endtask : rd

   task automatic rdLong(input logic [14:0] a, input int n,
                         output int flips);
      nst_byte_t last;
      flips = 0;
      @(posedge core_clk);
      bus <= '{1'b0, 1'b0, 1'b1, a};
      repeat (2) @(posedge core_clk);
      last = rdData;
      repeat (n) begin
         @(posedge core_clk);
         if (rdData[0] !== last[0]) flips++;
         last = rdData;
      end
      bus <= IDLE;
   endtask : rdLong

endmodule : nst_host_model

`default_nettype wire

// *** sim/nst_timekeeper_tb.sv ***
// Bench for the timekeeping RAM: host model plus reference model.
// Assumes nst_pkg is compiled first; the checker binds itself.
`default_nettype none

module nst_timekeeper_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import nst_pkg::*;

   // --------
   // signals and reference model
   // --------
   localparam int SEC = 40;
   localparam int TOG = 5;
   logic        core_clk;
   logic        rst_n;
   logic        powerFail;
   logic        batteryGood;
   logic        byteLinesOe;
   logic        oscillatorStopped;
   logic        updatesFrozen;
   logic        o;
   logic [14:0] a;
   nst_bus_s    hostBus;
   nst_byte_t   byteLinesIn;
   nst_byte_t   byteLinesOut;
   nst_byte_t   s1;
   nst_byte_t   s2;
   nst_byte_t   setVal [8];
   nst_byte_t   memModel [int];
   int          n_fail = 0;
   int          checked = 0;
   int          y, m, flips;

   nst_timekeeper #(.SEC_CYCLES(SEC), .TOG_CYCLES(TOG)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .hostBus(hostBus),
      .byteLinesIn(byteLinesIn), .byteLinesOut(byteLinesOut),
      .byteLinesOe(byteLinesOe), .powerFail(powerFail),
      .batteryGood(batteryGood), .oscillatorStopped(oscillatorStopped),
      .updatesFrozen(updatesFrozen));

   nst_host_model host (.core_clk(core_clk), .bus(hostBus),
      .wrData(byteLinesIn), .rdData(byteLinesOut), .rdOe(byteLinesOe));

   function automatic int dim(int yr, int mo);
      if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
      if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
      return 31;
   endfunction : dim

   function automatic nst_byte_t bcd(int v);
      return nst_byte_t'(((v / 10) << 4) | (v % 10));
   endfunction : bcd

   task automatic cmp(input nst_byte_t got, input nst_byte_t exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic rdChk(input logic [14:0] ad, input nst_byte_t exp);
      nst_byte_t v;
      logic oe;
      host.rd(ad, v, oe);
      cmp({7'h0, oe}, 8'h01);
      cmp(v, exp);
   endtask : rdChk

   task automatic test_done();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // whole run needs about 730 cycles
   initial begin
      #200000;
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      powerFail = 1'b0;
      batteryGood = 1'b1;
      void'($urandom(32'h8FA1C92E));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      rdChk(15'h7FF8, 8'h20);
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 15'h7FF7 : 15'($urandom_range(32'h7FF7));
         memModel[a] = nst_byte_t'($urandom);
         host.wr(a, memModel[a]);
         rdChk(a, memModel[a]);
      end
      host.idle(1);
      powerFail <= 1'b1;
      host.wr(a, ~memModel[a]);
      host.rd(a, s1, o);
      cmp({7'h0, o}, 8'h00);
      powerFail <= 1'b0;
      rdChk(a, memModel[a]);
      $display("memory test done");
      for (int i = 0; i < 4; i++) begin
         y = (i < 2) ? 23 + i : $urandom_range(98);
         m = (i < 2) ? 2 : $urandom_range(12, 1);
         batteryGood <= 1'($urandom);
         setVal = '{8'hA0, 8'h59, 8'h59, 8'h23, 8'h07,
                    bcd(dim(y, m)), bcd(m), bcd(y)};
         for (int j = 0; j < 8; j++)
            host.wr(15'h7FF8 + 15'(j), setVal[j]);
         host.wr(15'h7FF8, 8'h20);
         host.idle(50);
         host.wr(15'h7FF8, 8'h60);
         host.idle(1);
         rdChk(15'h7FFA, 8'h00);
         cmp({7'h0, updatesFrozen}, 8'h01);
         rdChk(15'h7FFB, 8'h00);
         rdChk(15'h7FFC, {batteryGood, 7'h01});
         rdChk(15'h7FFD, 8'h01);
         rdChk(15'h7FFE, bcd(m % 12 + 1));
         rdChk(15'h7FFF, bcd(m == 12 ? y + 1 : y));
         rdChk(15'h7FF8, 8'h60);
         host.rd(15'h7FF9, s1, o);
         cmp({7'h0, s1 < 8'h02}, 8'h01);
         host.wr(15'h7FF8, 8'h20);
         host.idle(20);
      end
      $display("calendar test done");
      host.wr(15'h7FF8, 8'h60);
      host.rd(15'h7FF9, s1, o);
      host.idle(90);
      rdChk(15'h7FF9, s1);
      host.wr(15'h7FF8, 8'h20);
      host.idle(20);
      host.wr(15'h7FF8, 8'h60);
      host.rd(15'h7FF9, s2, o);
      cmp({7'h0, s2 != s1}, 8'h01);
      host.wr(15'h7FF8, 8'h20);
      host.wr(15'h7FF9, 8'h80);
      host.idle(3);
      cmp({7'h0, oscillatorStopped}, 8'h01);
      host.rd(15'h7FF9, s1, o);
      host.idle(90);
      rdChk(15'h7FF9, s1);
      $display("hold and stop test done");
      host.wr(15'h7FF9, 8'h00);
      host.wr(15'h7FF8, 8'h60);
      host.wr(15'h7FFC, 8'h40);
      host.rdLong(15'h7FF9, 6 * TOG, flips);
      cmp({7'h0, flips inside {[5:7]}}, 8'h01);
      host.wr(15'h7FFC, 8'hC0);
      batteryGood <= 1'b0;
      rdChk(15'h7FFC, 8'h40);
      $display("test bit and flag test done");
      test_done();
   end

endmodule : nst_timekeeper_tb

`default_nettype wire
